// ### rtl/flash_read_defines.svh
// Constants of the serial flash read engine: opcodes, widths and counts.
`ifndef FLASH_READ_DEFINES_SVH
`define FLASH_READ_DEFINES_SVH

// ----------------------------------------------------------------------
// Read opcodes
// ----------------------------------------------------------------------
`define FR_OP_READ      8'h03
`define FR_OP_FAST      8'h0B
`define FR_OP_DUAL_OUT  8'h3B
`define FR_OP_QUAD_OUT  8'h6B
`define FR_OP_DUAL_IO   8'hBB
`define FR_OP_QUAD_IO   8'hEB

// ----------------------------------------------------------------------
// Field sizes in bits and lane widths in bits per clock
// ----------------------------------------------------------------------
`define FR_OPC_BITS     6'h08
`define FR_ADDR_BITS    6'h18
`define FR_MODE_BITS    6'h08
`define FR_BYTE_BITS    4'h8
`define FR_W1           3'h1
`define FR_W2           3'h2
`define FR_W4           3'h4

// ----------------------------------------------------------------------
// Dummy clock counts and mode key
// ----------------------------------------------------------------------
`define FR_SPI_DUMMY    4'h8
`define FR_QIO_DUMMY    4'h4
`define FR_NO_DUMMY     4'h0
`define FR_QPI_MODE_CLK 4'h2
`define FR_CONT_KEY     2'h2
`define FR_RP_RESET     2'h0

// ----------------------------------------------------------------------
// Lane drive patterns (enable is low while driving)
// ----------------------------------------------------------------------
`define FR_LANES_OFF    4'hF
`define FR_MASK_W1      4'hD
`define FR_MASK_W2      4'hC
`define FR_MASK_W4      4'h0

`endif

// ### rtl/flash_read_pkg.sv
// Types shared by the serial flash read engine and its bench.
package flash_read_pkg;

   // Phases of one chip-select frame.
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE
   } phase_t;

   // Shape of a decoded read command.
   typedef struct packed
   {
      logic       valid;   // Command accepted.
      logic [2:0] addrW;   // Address bits per clock.
      logic       modeOn;  // Continuous-read bits follow the address.
      logic [3:0] dummy;   // Dummy clocks before data.
      logic [2:0] dataW;   // Data bits per clock.
   } read_cmd_t;

   // Output side of the four IO lanes.
   typedef struct packed
   {
      logic [3:0] value;   // Level driven on each lane.
      logic [3:0] enN;     // Low while the lane is driven.
   } lane_drive_t;

endpackage

// ### rtl/read_fifo.sv
// Synchronous FIFO between the array fetcher and the output shifter.
`timescale 1ns/100ps

module read_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock, reset and flush
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   localparam int PW = $clog2(DEPTH);

   // -------------------------------------------------------------------
   // Storage and pointers
   // -------------------------------------------------------------------
   logic [WIDTH-1:0] store [DEPTH];   // Word storage.
   logic [PW-1:0]    wrPtr;           // Next slot to write.
   logic [PW-1:0]    rdPtr;           // Next slot to read.
   logic [PW:0]      fill;            // Words held.

   wire push = inValid & inReady;
   wire pop  = outValid & outReady;

   // Full and empty come straight from the word count.
   assign inReady  = (fill != (PW+1)'(DEPTH)) & ~flush;
   assign outValid = (fill != '0) & ~flush;
   assign outData  = store[rdPtr];

   // Pointer and count update; a flush empties the FIFO at once.
   always_ff @(posedge clk)
   begin
      if (rst | flush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill  <= '0;
      end
      else
      begin
         wrPtr <= push ? PW'(wrPtr + 1'b1) : wrPtr;
         rdPtr <= pop ? PW'(rdPtr + 1'b1) : rdPtr;
         fill  <= (PW+1)'(fill + push - pop);
      end
   end

   // Word write.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         store[wrPtr] <= inData;
      end
   end

endmodule

// ### rtl/serial_flash_read_engine.sv
// Read-command engine of a serial NOR flash on the serial clock pins.
`timescale 1ns/100ps
`include "flash_read_defines.svh"

// How it works
// - Single read: opcode 03h, 24-bit address, MSB first.
// - Opcode and address sampled on rising clock.
// - Data driven MSB first on falling edges.
// - Address increments per byte until chip select rises.
// - Reads ignored while a write cycle runs.
// - Plain read refused in four-lane command mode.
// - Fast read adds eight dummy clocks outside four-lane mode.
// - Four-lane fast read dummy from select field.
// - Dummy select resets to two clocks.
// - Dual output read: eight dummies, two lanes.
// - Quad output read needs quad lane enable.
// - Dual IO read: address and data two lanes.
// - Eight continuous-read bits follow the address.
// - Select 10 lets next dual access skip opcode.
// - Quad IO read: four lanes, four dummies outside four-lane mode.
// - Quad IO read needs quad lane enable.
// - Select 10 lets next quad access skip opcode.
// - Four-lane mode: opcode two clocks, address six.
// - Busy status follows the write cycle.
module serial_flash_read_engine #(
   parameter int MEM_BYTES  = 256,
   parameter int FIFO_DEPTH = 16
)
(
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   // Serial link pins
   input  wire logic                      csN,
   input  wire logic                      serialClock,
   input  wire logic [3:0]                laneIn,
   output flash_read_pkg::lane_drive_t    laneDrive,
   // Status and configuration
   input  wire logic                      writeCycleActive,
   input  wire logic                      quadLaneEnable,
   input  wire logic                      fourLaneCommandMode,
   input  wire logic [1:0]                dummySelectIn,
   input  wire logic                      dummySelectLoad,
   input  wire logic                      readParamReset,
   output logic                           busyStatus,
   output logic                           contReadActive,
   // Array load port
   input  wire logic                      memWrite,
   input  wire logic [$clog2(MEM_BYTES)-1:0] memAddr,
   input  wire logic [7:0]                memData
);
   import flash_read_pkg::*;
   localparam int AW = $clog2(MEM_BYTES);

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------
   // Shifts one clock's worth of input bits into the collector.
   function automatic logic [31:0] shiftBits(input logic [31:0] sh,
                                             input logic [2:0]  w,
                                             input logic [3:0]  lanes);
      unique case (w)
         `FR_W2:  shiftBits = {sh[29:0], lanes[1:0]};
         `FR_W4:  shiftBits = {sh[27:0], lanes};
         default: shiftBits = {sh[30:0], lanes[0]};
      endcase
   endfunction
   // Places the top bits of a byte on the lanes for a data width.
   function automatic lane_drive_t placeBits(input logic [7:0] b,
                                             input logic [2:0] w);
      unique case (w)
         `FR_W2:  placeBits = '{value: {2'h0, b[7:6]}, enN: `FR_MASK_W2};
         `FR_W4:  placeBits = '{value: b[7:4], enN: `FR_MASK_W4};
         default: placeBits = '{value: {2'h0, b[7], 1'h0},
                                enN: `FR_MASK_W1};
      endcase
   endfunction
   // Decodes an opcode into the shape of its read command.
   function automatic read_cmd_t decodeCmd(input logic [7:0] op,
                                           input logic       four_lane_command_mode,
                                           input logic       qe,
                                           input logic       busy,
                                           input logic [1:0] sel);
      logic [3:0] qpiDummy;
      qpiDummy  = 4'({1'h0, sel, 1'h0} + 4'h2);
      decodeCmd = '{valid: 1'h0, addrW: `FR_W1, modeOn: 1'h0,
                    dummy: `FR_NO_DUMMY, dataW: `FR_W1};
      unique case (op)
         `FR_OP_READ: decodeCmd.valid = ~four_lane_command_mode;
         `FR_OP_FAST:
         begin
            decodeCmd.valid = 1'h1;
            decodeCmd.dummy = four_lane_command_mode ? qpiDummy : `FR_SPI_DUMMY;
            decodeCmd.addrW = four_lane_command_mode ? `FR_W4 : `FR_W1;
            decodeCmd.dataW = four_lane_command_mode ? `FR_W4 : `FR_W1;
         end
         `FR_OP_DUAL_OUT:
         begin
            decodeCmd.valid = ~four_lane_command_mode;
            decodeCmd.dummy = `FR_SPI_DUMMY;
            decodeCmd.dataW = `FR_W2;
         end
         `FR_OP_QUAD_OUT:
         begin
            decodeCmd.valid = ~four_lane_command_mode & qe;
            decodeCmd.dummy = `FR_SPI_DUMMY;
            decodeCmd.dataW = `FR_W4;
         end
         `FR_OP_DUAL_IO:
         begin
            decodeCmd.valid  = ~four_lane_command_mode;
            decodeCmd.addrW  = `FR_W2;
            decodeCmd.modeOn = 1'h1;
            decodeCmd.dataW  = `FR_W2;
         end
         `FR_OP_QUAD_IO:
         begin
            decodeCmd.valid  = qe;
            decodeCmd.addrW  = `FR_W4;
            decodeCmd.modeOn = 1'h1;
            decodeCmd.dummy  = four_lane_command_mode ? 4'(qpiDummy - `FR_QPI_MODE_CLK)
                                   : `FR_QIO_DUMMY;
            decodeCmd.dataW  = `FR_W4;
         end
         default: decodeCmd.valid = 1'h0;
      endcase
      decodeCmd.valid = decodeCmd.valid & ~busy;
   endfunction

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   logic [1:0] csPipe;     // Chip select, two stages.
   logic [2:0] sclkPipe;   // Serial clock, two stages plus edge history.
   logic [3:0] laneMeta;   // Lanes, first stage.
   logic [3:0] laneSync;   // Lanes, second stage.
   // Chip select, serial clock and lanes pass two flip-flops before any logic reads them.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         csPipe   <= 2'h3;
         sclkPipe <= 3'h0;
         laneMeta <= 4'h0;
         laneSync <= 4'h0;
      end
      else
      begin
         csPipe   <= {csPipe[0], csN};
         sclkPipe <= {sclkPipe[1:0], serialClock};
         laneMeta <= laneIn;
         laneSync <= laneMeta;
      end
   end
   wire csHigh   = csPipe[1];
   wire sclkRise = sclkPipe[1] & ~sclkPipe[2];
   wire sclkFall = ~sclkPipe[1] & sclkPipe[2];

   // -------------------------------------------------------------------
   // Command state
   // -------------------------------------------------------------------
   phase_t      phase;        // Frame phase.
   read_cmd_t   cmd;          // Current command shape.
   logic [7:0]  contOpcode;   // Opcode reused in continuous-read mode.
   logic        contMode;     // Next frame skips the opcode.
   logic [31:0] shiftIn;      // Input bit collector.
   logic [5:0]  bitCnt;       // Bits collected in this phase.
   logic [3:0]  dummyLeft;    // Dummy clocks still to come.
   logic [1:0]  readParam;    // Four-lane dummy select.
   logic [23:0] fetchAddr;    // Next array address to prefetch.
   logic        fetchOn;      // Prefetcher running.
   logic [7:0]  outByte;      // Byte being shifted out.
   logic [3:0]  outBitsLeft;  // Bits of outByte not yet driven.
   // Bits per clock of the phase in progress.
   wire [2:0] opW    = fourLaneCommandMode ? `FR_W4 : `FR_W1;
   wire [2:0] curW   = (phase == ST_OPCODE) ? opW : cmd.addrW;
   wire [31:0] nextShift = shiftBits(shiftIn, curW, laneSync);
   wire [5:0] cntNext    = 6'(bitCnt + {3'h0, curW});
   wire read_cmd_t opCmd = decodeCmd(nextShift[7:0], fourLaneCommandMode,
                                     quadLaneEnable, busyStatus, readParam);
   wire read_cmd_t contCmd = decodeCmd(contOpcode, fourLaneCommandMode,
                                       quadLaneEnable, busyStatus, readParam);
   wire phase_t afterAddr = cmd.modeOn ? ST_MODE :
                            (cmd.dummy != `FR_NO_DUMMY) ? ST_DUMMY :
                            ST_DATA;
   wire phase_t afterMode = (cmd.dummy != `FR_NO_DUMMY) ? ST_DUMMY :
                            ST_DATA;

   // -------------------------------------------------------------------
   // Data path: array, prefetcher and FIFO
   // -------------------------------------------------------------------
   logic [7:0] mem [MEM_BYTES];   // Array contents.
   wire        fifoInReady;       // FIFO can take a byte.
   wire        fifoOutValid;      // FIFO holds a byte.
   wire [7:0]  fifoOutData;       // Oldest byte.
   wire        needByte = (phase == ST_DATA) & sclkFall &
                          (outBitsLeft == 4'h0);
   wire        fetchPush = fetchOn & fifoInReady;
   // Array load port.
   always_ff @(posedge ref_clk)
   begin
      if (memWrite)
         mem[memAddr] <= memData;
   end
   // The FIFO is flushed whenever chip select is high.
   read_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk      (ref_clk),
      .rst      (rst),
      .flush    (csHigh),
      .inValid  (fetchOn),
      .inReady  (fifoInReady),
      .inData   (mem[fetchAddr[AW-1:0]]),
      .outValid (fifoOutValid),
      .outReady (needByte),
      .outData  (fifoOutData)
   );

   // Prefetcher walks the array while the FIFO has room.
   always_ff @(posedge ref_clk)
   begin
      if (rst | csHigh)
         fetchOn <= 1'h0;
      else if (phase == ST_ADDR && sclkRise && cntNext == `FR_ADDR_BITS)
      begin
         fetchOn   <= 1'h1;
         fetchAddr <= nextShift[23:0];
      end
      else if (fetchPush)
         fetchAddr <= 24'(fetchAddr + 1'b1);
   end

   // -------------------------------------------------------------------
   // Status and configuration
   // -------------------------------------------------------------------
   // Busy mirror and four-lane dummy select.
   always_ff @(posedge ref_clk)
   begin
      if (rst | readParamReset)
         readParam <= `FR_RP_RESET;
      else if (dummySelectLoad)
         readParam <= dummySelectIn;
      busyStatus <= rst ? 1'h0 : writeCycleActive;
   end
   // The continuous-read flag leaves straight from its flip-flop.
   assign contReadActive = contMode;

   // -------------------------------------------------------------------
   // Command sequencer on rising serial clock edges
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         phase    <= ST_IDLE;
         contMode <= 1'h0;
         bitCnt   <= 6'h00;
         shiftIn  <= 32'h0;
      end
      else if (csHigh)
      begin
         phase  <= ST_IDLE;
         bitCnt <= 6'h00;
      end
      else if (phase == ST_IDLE)
      begin
         // A frame starts; continuous mode goes straight to the address.
         cmd   <= contCmd;
         phase <= !contMode ? ST_OPCODE :
                  contCmd.valid ? ST_ADDR : ST_IGNORE;
      end
      else if (sclkRise)
      begin
         shiftIn <= nextShift;
         bitCnt  <= cntNext;
         unique case (phase)
            ST_OPCODE:
            if (cntNext == `FR_OPC_BITS)
            begin
               cmd        <= opCmd;
               contOpcode <= nextShift[7:0];
               bitCnt     <= 6'h00;
               phase      <= opCmd.valid ? ST_ADDR : ST_IGNORE;
            end
            ST_ADDR:
            if (cntNext == `FR_ADDR_BITS)
            begin
               bitCnt    <= 6'h00;
               dummyLeft <= cmd.dummy;
               phase     <= afterAddr;
            end
            ST_MODE:
            if (cntNext == `FR_MODE_BITS)
            begin
               contMode <= nextShift[5:4] == `FR_CONT_KEY;
               phase    <= afterMode;
            end
            ST_DUMMY:
            begin
               dummyLeft <= 4'(dummyLeft - 1'b1);
               if (dummyLeft == 4'h1)
                  phase <= ST_DATA;
            end
            ST_DATA, ST_IGNORE, ST_IDLE: bitCnt <= 6'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Output shifter on falling serial clock edges
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst | csHigh | phase != ST_DATA)
      begin
         laneDrive   <= '{value: 4'h0, enN: `FR_LANES_OFF};
         outBitsLeft <= 4'h0;
         outByte     <= 8'h00;
      end
      else if (needByte && fifoOutValid)
      begin
         laneDrive   <= placeBits(fifoOutData, cmd.dataW);
         outByte     <= 8'(fifoOutData << cmd.dataW);
         outBitsLeft <= 4'(`FR_BYTE_BITS - {1'h0, cmd.dataW});
      end
      else if (sclkFall && outBitsLeft != 4'h0)
      begin
         laneDrive   <= placeBits(outByte, cmd.dataW);
         outByte     <= 8'(outByte << cmd.dataW);
         outBitsLeft <= 4'(outBitsLeft - {1'h0, cmd.dataW});
      end
   end
endmodule

// ### verif/flash_read_chk.sv
// Concurrent checks on the pins of the flash read engine.
`timescale 1ns/100ps

module flash_read_chk
(
   // Clock and reset
   input wire logic                        ref_clk,
   input wire logic                        rst,
   // Pins watched
   input wire logic                        csN,
   input wire logic                        serialClock,
   input wire flash_read_pkg::lane_drive_t laneDrive,
   input wire logic                        writeCycleActive,
   input wire logic                        quadLaneEnable,
   input wire logic                        fourLaneCommandMode,
   input wire logic                        busyStatus,
   input wire logic                        contReadActive
);
   import flash_read_pkg::*;
   logic [3:0] sinceFall; // Cycles since the last serial clock fall.
   logic       scPrev;    // Serial clock one cycle ago.

   // Counts from each falling serial clock edge and saturates.
   always_ff @(posedge ref_clk)
   begin
      scPrev <= serialClock;
      if (rst)
         sinceFall <= 4'hF;
      else if (scPrev && !serialClock)
         sinceFall <= 4'h0;
      else if (sinceFall != 4'hF)
         sinceFall <= sinceFall + 4'h1;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Lanes stay released through the opening clocks of a frame.
   sequence quiet8;
      (laneDrive.enN == 4'hF) [*8];
   endsequence

   reset_state_a: assert property (
      disable iff (1'b0) rst |=> laneDrive.enN == 4'hF && !busyStatus)
      else $error("lanes or status not cleared by reset");
   busy_rise_a: assert property (
      $rose(writeCycleActive) |=> busyStatus)
      else $error("busy status missed a write cycle");
   busy_refuse_a: assert property (
      busyStatus [*8] |-> laneDrive.enN == 4'hF)
      else $error("lanes driven while busy");
   quad_gate_a: assert property (
      (!quadLaneEnable && !fourLaneCommandMode) [*5]
      |-> laneDrive.enN[3:2] == 2'b11)
      else $error("upper lanes driven without quad enable");
   lane_mask_a: assert property (
      laneDrive.enN inside {4'hF, 4'hD, 4'hC, 4'h0})
      else $error("illegal lane enable pattern");
   lane_release_a: assert property (
      csN [*6] |-> laneDrive.enN == 4'hF)
      else $error("lanes driven after chip select rose");
   frame_start_a: assert property (
      $fell(csN) |-> quiet8)
      else $error("lanes driven during opcode");
   value_edge_a: assert property (
      laneDrive.enN != 4'hF && $past(laneDrive.enN) != 4'hF
      && $changed(laneDrive.value) |-> sinceFall <= 4'h6)
      else $error("lane value moved away from a falling edge");
endmodule

bind serial_flash_read_engine flash_read_chk chk
(
   .ref_clk(ref_clk), .rst(rst), .csN(csN), .serialClock(serialClock),
   .laneDrive(laneDrive), .writeCycleActive(writeCycleActive),
   .quadLaneEnable(quadLaneEnable), .busyStatus(busyStatus),
   .fourLaneCommandMode(fourLaneCommandMode),
   .contReadActive(contReadActive)
);

// ### verif/flash_host_model.sv
// Behavioural serial host that clocks frames into the read engine.
`timescale 1ns/100ps

module flash_host_model
(
   // Clock
   input  wire logic                        ref_clk,
   // Link pins
   output logic                             csN,
   output logic                             serialClock,
   output logic [3:0]                       laneIn,
   input  wire flash_read_pkg::lane_drive_t laneDrive
);
   import flash_read_pkg::*;
   logic [3:0] hostVal = 4'h0; // Levels the host drives.
   logic [3:0] hostOe  = 4'h0; // Lanes the host drives.
   logic       noise   = 1'b0; // Toggles so a floating lane never settles.
   int         half    = 4;    // Half serial period in clock cycles.

   initial
   begin
      csN = 1'b1;
      serialClock = 1'b0;
   end

   // A released lane must not show a stale level.
   always @(posedge ref_clk)
      noise <= !noise;

   // Each lane merges device drive, host drive and float.
   always_comb
      for (int i = 0; i < 4; i++)
         laneIn[i] = !laneDrive.enN[i] ? laneDrive.value[i] :
                     hostOe[i] ? hostVal[i] : noise ^ i[0];

   task automatic tick();
      repeat (half) @(negedge ref_clk);
   endtask

   task automatic startFrame();
      csN = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask

   // Shifts n bits MSB first, w lanes per clock, lane 0 lowest.
   task automatic sendBits(input logic [31:0] v, input int n, input int w);
      for (int k = n - w; k >= 0; k -= w)
      begin
         serialClock = 1'b0;
         hostOe = 4'((1 << w) - 1);
         hostVal = 4'(v >> k);
         tick();
         serialClock = 1'b1;
         tick();
      end
   endtask

   // Collects one byte, sampling just before each rising edge.
   task automatic recvBits(output logic [7:0] v, input int w);
      v = 8'h00;
      for (int k = 0; k < 8; k += w)
      begin
         hostOe = 4'h0;
         serialClock = 1'b0;
         tick();
         v = (v << w) | 8'(w == 4 ? laneIn : w == 2 ? laneIn[1:0] : laneIn[1]);
         serialClock = 1'b1;
         tick();
      end
   endtask

   task automatic endFrame();
      serialClock = 1'b0;
      tick();
      csN = 1'b1;
      hostOe = 4'h0;
      repeat (8) @(negedge ref_clk);
   endtask
endmodule

// ### verif/serial_flash_read_engine_test.sv
// Self-checking bench for the serial flash read engine.
`timescale 1ns/100ps

module serial_flash_read_engine_test;
   import flash_read_pkg::*;
   logic        ref_clk;
   logic        rst = 1'b1;
   logic        csN;
   logic        serialClock;
   logic [3:0]  laneIn;
   lane_drive_t drv;
   logic        wrCycle = 1'b0;
   logic        qe = 1'b0;
   logic        flm = 1'b0;
   logic [1:0]  selIn = 2'h0;
   logic        selLoad = 1'b0;
   logic        parRst = 1'b0;
   logic        busy;
   logic        cont;
   logic        memWrite = 1'b0;
   logic [7:0]  memAddr = 8'h00;
   logic [7:0]  memData = 8'h00;
   logic [23:0] adr = 24'h0000FA; // Start address, near the wrap.
   int          err_count = 0;
   int          num_checks = 0;

   serial_flash_read_engine #(.MEM_BYTES(256), .FIFO_DEPTH(16)) dut
   (
      .ref_clk(ref_clk), .rst(rst), .csN(csN), .serialClock(serialClock),
      .laneIn(laneIn), .laneDrive(drv), .writeCycleActive(wrCycle),
      .quadLaneEnable(qe), .fourLaneCommandMode(flm),
      .dummySelectIn(selIn), .dummySelectLoad(selLoad),
      .readParamReset(parRst), .busyStatus(busy), .contReadActive(cont),
      .memWrite(memWrite), .memAddr(memAddr), .memData(memData)
   );

   flash_host_model h
   (
      .ref_clk(ref_clk), .csN(csN), .serialClock(serialClock),
      .laneIn(laneIn), .laneDrive(drv)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Array contents as a function of the address.
   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction

   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One read frame; a refused frame expects mask F and no data.
   task automatic rd(input logic [7:0] op, input int ow, aw,
                     input logic [7:0] md, input int mw, dm, dw, n,
                     input logic [3:0] msk);
      logic [7:0] v;
      h.startFrame();
      if (ow > 0)
         h.sendBits({24'h0, op}, 8, ow);
      h.sendBits({8'h0, adr}, 24, aw);
      if (mw > 0)
         h.sendBits({24'h0, md}, 8, mw);
      if (dm > 0)
         h.sendBits(32'h0, dm, 1);
      for (int i = 0; i < n; i++)
      begin
         h.recvBits(v, dw);
         if (msk != 4'hF)
            chk(pat(adr + 24'(i)), v);
         chk({4'h0, msk}, {4'h0, drv.enN});
      end
      h.endFrame();
      chk(8'h0F, {4'h0, drv.enN});
   endtask

   // Leaves continuous mode by holding lane 0 high.
   task automatic exitCont(input int n);
      h.startFrame();
      h.sendBits(32'hFFFFFFFF, n, 1);
      h.endFrame();
      chk(8'h00, {7'h0, cont});
   endtask

   initial
   begin
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 256; i++)
      begin
         memWrite = 1'b1;
         memAddr = 8'(i);
         memData = pat(24'(i));
         @(negedge ref_clk);
      end
      memWrite = 1'b0;
      rd(8'h03, 1, 1, 8'h00, 0, 0, 1, 8, 4'hD);
      h.half = 10;
      rd(8'h0B, 1, 1, 8'h00, 0, 8, 1, 18, 4'hD);
      h.half = 4;
      rd(8'h3B, 1, 1, 8'h00, 0, 8, 2, 3, 4'hC);
      rd(8'h6B, 1, 1, 8'h00, 0, 8, 4, 1, 4'hF);
      rd(8'hEB, 1, 4, 8'h20, 4, 4, 4, 1, 4'hF);
      qe = 1'b1;
      rd(8'h6B, 1, 1, 8'h00, 0, 8, 4, 3, 4'h0);
      rd(8'hBB, 1, 2, 8'h20, 2, 0, 2, 3, 4'hC);
      chk(8'h01, {7'h0, cont});
      rd(8'h00, 0, 2, 8'h20, 2, 0, 2, 3, 4'hC);
      exitCont(16);
      rd(8'hEB, 1, 4, 8'h25, 4, 4, 4, 3, 4'h0);
      chk(8'h01, {7'h0, cont});
      rd(8'h00, 0, 4, 8'h2F, 4, 4, 4, 3, 4'h0);
      exitCont(8);
      wrCycle = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(8'h01, {7'h0, busy});
      rd(8'h03, 1, 1, 8'h00, 0, 0, 1, 1, 4'hF);
      wrCycle = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(8'h00, {7'h0, busy});
      flm = 1'b1;
      rd(8'h03, 4, 4, 8'h00, 0, 0, 4, 1, 4'hF);
      rd(8'h0B, 4, 4, 8'h00, 0, 2, 4, 2, 4'h0);
      for (int s = 0; s < 4; s++)
      begin
         selIn = 2'(s);
         selLoad = 1'b1;
         @(negedge ref_clk);
         selLoad = 1'b0;
         rd(8'h0B, 4, 4, 8'h00, 0, 2 + 2 * s, 4, 2, 4'h0);
      end
      parRst = 1'b1;
      @(negedge ref_clk);
      parRst = 1'b0;
      rd(8'h0B, 4, 4, 8'h00, 0, 2, 4, 2, 4'h0);
      rd(8'hEB, 4, 4, 8'h00, 4, 0, 4, 2, 4'h0);
      report_and_stop();
   end

   // Cuts a hang short well after the tests should have ended.
   initial
   begin
      #800000;
      err_count++;
      report_and_stop();
   end
endmodule
